/* File: src/cfd_config_fuse_decode.sv */
// Configuration byte store, table access port, power-on decode and self-write protection.
`timescale 1ns/10ps
module cfd_config_fuse_decode #(
    parameter logic [63:0] CFG_INIT = 64'hFFFF_FFFF_FFFF_FFFF,
    parameter int ADDR_WIDTH = cfd_pkg::ADDR_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tbl_rd,
    input wire logic tbl_wr,
    input wire logic [ADDR_WIDTH-1:0] tbl_addr,
    input wire logic [7:0] tbl_wdata,
    output logic [7:0] tbl_rdata,
    output logic tbl_rvalid,
    input wire logic self_wr_req,
    input wire logic [ADDR_WIDTH-1:0] self_wr_addr,
    output logic self_wr_accept,
    output logic self_wr_reject,
    output logic cfg_loaded,
    output logic boot_segment_present,
    output logic boot_high_security,
    output logic [ADDR_WIDTH-1:0] boot_segment_end,
    output logic boot_write_protect,
    output logic general_code_protect,
    output logic general_write_protect,
    output logic two_speed_startup_enable,
    output logic low_power_rc_power_select,
    output logic secondary_osc_pin_source,
    output cfd_pkg::cfd_osc_e initial_oscillator_select
);

    if (ADDR_WIDTH != cfd_pkg::ADDR_W) begin : g_width_check
        $error("cfd_config_fuse_decode supports only a 24-bit address");
    end
    if (cfd_pkg::NUM_CFG * 8 != $bits(CFG_INIT)) begin : g_image_check
        $error("cfd_config_fuse_decode needs one image byte per configuration byte");
    end

    // Maps an address to a configuration byte index; bit 3 flags a hit.
    function automatic logic [3:0] cfd_addr_index(input logic [23:0] addr);
        case (addr)
            cfd_pkg::BOOT_SEG_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_BOOT};
            cfd_pkg::GEN_SEG_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_GEN};
            cfd_pkg::OSC_SEL_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_OSC_SEL};
            cfd_pkg::OSC_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_OSC};
            cfd_pkg::WDT_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_WDT};
            cfd_pkg::POR_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_POR};
            cfd_pkg::DBG_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_DBG};
            cfd_pkg::DSLP_CFG_ADDR: cfd_addr_index = {1'b1, cfd_pkg::IDX_DSLP};
            default: cfd_addr_index = 4'h0;
        endcase
    endfunction : cfd_addr_index

    // Mask of the bits that exist in a given configuration byte.
    function automatic logic [7:0] cfd_impl_mask(input logic [2:0] idx);
        case (idx)
            cfd_pkg::IDX_BOOT: cfd_impl_mask = cfd_pkg::BOOT_IMPL_MASK;
            cfd_pkg::IDX_GEN: cfd_impl_mask = cfd_pkg::GEN_IMPL_MASK;
            cfd_pkg::IDX_OSC_SEL: cfd_impl_mask = cfd_pkg::OSC_SEL_IMPL_MASK;
            default: cfd_impl_mask = cfd_pkg::FULL_MASK;
        endcase
    endfunction : cfd_impl_mask

    // Last address of the boot segment for a size code, zero when absent.
    function automatic logic [23:0] cfd_boot_end(input logic [2:0] bss);
        case (bss)
            cfd_pkg::BSS_STD_SMALL, cfd_pkg::BSS_HIGH_SMALL: cfd_boot_end = cfd_pkg::BOOT_END_SMALL;
            cfd_pkg::BSS_STD_MID, cfd_pkg::BSS_HIGH_MID: cfd_boot_end = cfd_pkg::BOOT_END_MID;
            cfd_pkg::BSS_STD_LARGE, cfd_pkg::BSS_HIGH_LARGE: cfd_boot_end = cfd_pkg::BOOT_END_LARGE;
            default: cfd_boot_end = 24'h000000;
        endcase
    endfunction : cfd_boot_end

    // Nonvolatile byte store, reloaded from the programmed image at reset.
    logic [7:0] cfg_mem_r [cfd_pkg::NUM_CFG];
    logic [7:0] cfg_mem_nxt [cfd_pkg::NUM_CFG];
    cfd_pkg::cfd_state_e state_r;
    cfd_pkg::cfd_state_e state_nxt;
    logic loaded_r;
    logic loaded_nxt;
    logic [7:0] tbl_rdata_r;
    logic [7:0] tbl_rdata_nxt;
    logic tbl_rvalid_r;
    logic tbl_rvalid_nxt;
    logic wr_accept_r;
    logic wr_accept_nxt;
    logic wr_reject_r;
    logic wr_reject_nxt;
    logic present_r;
    logic present_nxt;
    logic high_sec_r;
    logic high_sec_nxt;
    logic [23:0] boot_end_r;
    logic [23:0] boot_end_nxt;
    logic boot_wp_r;
    logic boot_wp_nxt;
    logic gen_cp_r;
    logic gen_cp_nxt;
    logic gen_wp_r;
    logic gen_wp_nxt;
    logic two_speed_r;
    logic two_speed_nxt;
    logic low_power_rc_oscillator_pwr_r;
    logic low_power_rc_oscillator_pwr_nxt;
    logic secondary_oscillator_src_r;
    logic secondary_oscillator_src_nxt;
    cfd_pkg::cfd_osc_e init_osc_r;
    cfd_pkg::cfd_osc_e init_osc_nxt;
    logic [3:0] rd_hit;
    logic [3:0] wr_hit;
    logic [2:0] bss_code;
    logic in_boot;
    logic in_general;
    logic early_blocked;
    logic boot_blocked;
    logic general_blocked;

    assign rd_hit = cfd_addr_index(tbl_addr);
    assign wr_hit = cfd_addr_index(tbl_addr);
    assign bss_code = cfg_mem_r[cfd_pkg::IDX_BOOT][cfd_pkg::BOOT_BSS_LSB +: 3];
    // The boot range is tested first so that a boot address is never also judged as general code.
    assign in_boot = present_r && self_wr_addr >= cfd_pkg::BOOT_SEG_START && self_wr_addr <= boot_end_r;
    assign in_general = !in_boot && self_wr_addr < cfd_pkg::CFG_SPACE_BASE;
    // A write is rejected until the fields are latched, since the protect bits are not yet known.
    assign early_blocked = state_r != cfd_pkg::CFD_ST_READY;
    assign boot_blocked = in_boot && boot_wp_r;
    assign general_blocked = in_general && gen_wp_r;

    // Table access port into the configuration store.
    always_comb begin
        for (int i = 0; i < cfd_pkg::NUM_CFG; i++) begin
            cfg_mem_nxt[i] = cfg_mem_r[i];
        end
        tbl_rvalid_nxt = tbl_rd;
        // Data is zero outside a read so that the bus never shows a stale byte.
        tbl_rdata_nxt = 8'h00;
        if (tbl_rd && rd_hit[3]) begin
            tbl_rdata_nxt = cfg_mem_r[rd_hit[2:0]] & cfd_impl_mask(rd_hit[2:0]);
        end
        // Only the general byte is clear-only; other bytes are stored whole and masked on read.
        if (tbl_wr && wr_hit[3]) begin
            if (wr_hit[2:0] == cfd_pkg::IDX_GEN) begin
                cfg_mem_nxt[cfd_pkg::IDX_GEN] = cfg_mem_r[cfd_pkg::IDX_GEN] & (tbl_wdata | ~cfd_pkg::GEN_IMPL_MASK);
            end else begin
                cfg_mem_nxt[wr_hit[2:0]] = tbl_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < cfd_pkg::NUM_CFG; i++) begin
                cfg_mem_r[i] <= CFG_INIT[i*8 +: 8];
            end
            tbl_rvalid_r <= 1'b0;
            tbl_rdata_r <= 8'h00;
        end else begin
            for (int i = 0; i < cfd_pkg::NUM_CFG; i++) begin
                cfg_mem_r[i] <= cfg_mem_nxt[i];
            end
            tbl_rvalid_r <= tbl_rvalid_nxt;
            tbl_rdata_r <= tbl_rdata_nxt;
        end
    end

    // Decode after reset; the decoded fields then stay fixed until the next reset.
    always_comb begin
        state_nxt = state_r;
        present_nxt = present_r;
        high_sec_nxt = high_sec_r;
        boot_end_nxt = boot_end_r;
        boot_wp_nxt = boot_wp_r;
        gen_cp_nxt = gen_cp_r;
        gen_wp_nxt = gen_wp_r;
        two_speed_nxt = two_speed_r;
        low_power_rc_oscillator_pwr_nxt = low_power_rc_oscillator_pwr_r;
        secondary_oscillator_src_nxt = secondary_oscillator_src_r;
        init_osc_nxt = init_osc_r;
        case (state_r)
            cfd_pkg::CFD_ST_INIT: begin
                state_nxt = cfd_pkg::CFD_ST_LOAD;
            end
            cfd_pkg::CFD_ST_LOAD: begin
                state_nxt = cfd_pkg::CFD_ST_READY;
                // The reserved code is folded into the no-segment case so it never opens a protected range.
                present_nxt = bss_code != cfd_pkg::BSS_NONE && bss_code != cfd_pkg::BSS_RESERVED;
                high_sec_nxt = present_nxt && !bss_code[2];
                boot_end_nxt = cfd_boot_end(bss_code);
                boot_wp_nxt = !cfg_mem_r[cfd_pkg::IDX_BOOT][cfd_pkg::BOOT_WRP_BIT];
                gen_cp_nxt = !cfg_mem_r[cfd_pkg::IDX_GEN][cfd_pkg::GEN_CP_BIT];
                gen_wp_nxt = !cfg_mem_r[cfd_pkg::IDX_GEN][cfd_pkg::GEN_WRP_BIT];
                two_speed_nxt = cfg_mem_r[cfd_pkg::IDX_OSC_SEL][cfd_pkg::OSC_TWO_SPEED_BIT];
                low_power_rc_oscillator_pwr_nxt = cfg_mem_r[cfd_pkg::IDX_OSC_SEL][cfd_pkg::OSC_LOW_POWER_RC_OSCILLATOR_PWR_BIT];
                secondary_oscillator_src_nxt = cfg_mem_r[cfd_pkg::IDX_OSC_SEL][cfd_pkg::OSC_SECONDARY_OSCILLATOR_SRC_BIT];
                init_osc_nxt = cfd_pkg::cfd_osc_e'(cfg_mem_r[cfd_pkg::IDX_OSC_SEL][cfd_pkg::OSC_INIT_LSB +: 3]);
            end
            cfd_pkg::CFD_ST_READY: begin
                state_nxt = cfd_pkg::CFD_ST_READY;
            end
            default: begin
                state_nxt = cfd_pkg::CFD_ST_INIT;
            end
        endcase
        // The loaded flag follows the next state so that it rises on the same edge as the fields.
        loaded_nxt = state_nxt == cfd_pkg::CFD_ST_READY;
    end

    // Self-write screening; nothing is accepted until the fields are latched.
    // Exactly one of accept and reject pulses for each request.
    always_comb begin
        wr_accept_nxt = 1'b0;
        wr_reject_nxt = 1'b0;
        if (self_wr_req) begin
            if (early_blocked || boot_blocked || general_blocked) begin
                wr_reject_nxt = 1'b1;
            end else begin
                wr_accept_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_accept_r <= 1'b0;
            wr_reject_r <= 1'b0;
        end else begin
            wr_accept_r <= wr_accept_nxt;
            wr_reject_r <= wr_reject_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Before the decode the fields show the erased settings of an unprogrammed part.
            state_r <= cfd_pkg::CFD_ST_INIT;
            loaded_r <= 1'b0;
            present_r <= 1'b0;
            high_sec_r <= 1'b0;
            boot_end_r <= 24'h000000;
            boot_wp_r <= 1'b0;
            gen_cp_r <= 1'b0;
            gen_wp_r <= 1'b0;
            two_speed_r <= 1'b1;
            low_power_rc_oscillator_pwr_r <= 1'b1;
            secondary_oscillator_src_r <= 1'b1;
            init_osc_r <= cfd_pkg::CFD_OSC_FAST_RC_DIVIDED;
        end else begin
            state_r <= state_nxt;
            loaded_r <= loaded_nxt;
            present_r <= present_nxt;
            high_sec_r <= high_sec_nxt;
            boot_end_r <= boot_end_nxt;
            boot_wp_r <= boot_wp_nxt;
            gen_cp_r <= gen_cp_nxt;
            gen_wp_r <= gen_wp_nxt;
            two_speed_r <= two_speed_nxt;
            low_power_rc_oscillator_pwr_r <= low_power_rc_oscillator_pwr_nxt;
            secondary_oscillator_src_r <= secondary_oscillator_src_nxt;
            init_osc_r <= init_osc_nxt;
        end
    end

    assign tbl_rdata = tbl_rdata_r;
    assign tbl_rvalid = tbl_rvalid_r;
    assign self_wr_accept = wr_accept_r;
    assign self_wr_reject = wr_reject_r;
    assign cfg_loaded = loaded_r;
    assign boot_segment_present = present_r;
    assign boot_high_security = high_sec_r;
    assign boot_segment_end = boot_end_r;
    assign boot_write_protect = boot_wp_r;
    assign general_code_protect = gen_cp_r;
    assign general_write_protect = gen_wp_r;
    assign two_speed_startup_enable = two_speed_r;
    assign low_power_rc_power_select = low_power_rc_oscillator_pwr_r;
    assign secondary_osc_pin_source = secondary_oscillator_src_r;
    assign initial_oscillator_select = init_osc_r;

endmodule : cfd_config_fuse_decode

/* File: src/cfd_pkg.sv */
// Constants and types shared by the configuration fuse decoder.
package cfd_pkg;

    localparam int ADDR_W = 24;
    localparam int NUM_CFG = 8;

    // Locations of the configuration bytes in the configuration space.
    localparam logic [23:0] BOOT_SEG_CFG_ADDR = 24'hF80000;
    localparam logic [23:0] GEN_SEG_CFG_ADDR = 24'hF80004;
    localparam logic [23:0] OSC_SEL_CFG_ADDR = 24'hF80006;
    localparam logic [23:0] OSC_CFG_ADDR = 24'hF80008;
    localparam logic [23:0] WDT_CFG_ADDR = 24'hF8000A;
    localparam logic [23:0] POR_CFG_ADDR = 24'hF8000C;
    localparam logic [23:0] DBG_CFG_ADDR = 24'hF8000E;
    localparam logic [23:0] DSLP_CFG_ADDR = 24'hF80010;
    localparam logic [23:0] CFG_SPACE_BASE = 24'h800000;

    // Array indices of the configuration bytes.
    localparam logic [2:0] IDX_BOOT = 3'h0;
    localparam logic [2:0] IDX_GEN = 3'h1;
    localparam logic [2:0] IDX_OSC_SEL = 3'h2;
    localparam logic [2:0] IDX_OSC = 3'h3;
    localparam logic [2:0] IDX_WDT = 3'h4;
    localparam logic [2:0] IDX_POR = 3'h5;
    localparam logic [2:0] IDX_DBG = 3'h6;
    localparam logic [2:0] IDX_DSLP = 3'h7;

    // Implemented-bit masks; unimplemented bits read as zero.
    localparam logic [7:0] BOOT_IMPL_MASK = 8'h0F;
    localparam logic [7:0] GEN_IMPL_MASK = 8'h03;
    localparam logic [7:0] OSC_SEL_IMPL_MASK = 8'hE7;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Field positions.
    localparam int BOOT_WRP_BIT = 0;
    localparam int BOOT_BSS_LSB = 1;
    localparam int GEN_WRP_BIT = 0;
    localparam int GEN_CP_BIT = 1;
    localparam int OSC_TWO_SPEED_BIT = 7;
    localparam int OSC_LOW_POWER_RC_OSCILLATOR_PWR_BIT = 6;
    localparam int OSC_SECONDARY_OSCILLATOR_SRC_BIT = 5;
    localparam int OSC_INIT_LSB = 0;

    // Boot segment size and security codes.
    localparam logic [2:0] BSS_NONE = 3'h7;
    localparam logic [2:0] BSS_RESERVED = 3'h3;
    localparam logic [2:0] BSS_STD_SMALL = 3'h6;
    localparam logic [2:0] BSS_HIGH_SMALL = 3'h2;
    localparam logic [2:0] BSS_STD_MID = 3'h5;
    localparam logic [2:0] BSS_HIGH_MID = 3'h1;
    localparam logic [2:0] BSS_STD_LARGE = 3'h4;
    localparam logic [2:0] BSS_HIGH_LARGE = 3'h0;

    // Boot segment bounds.
    localparam logic [23:0] BOOT_SEG_START = 24'h000200;
    localparam logic [23:0] BOOT_END_SMALL = 24'h000AFE;
    localparam logic [23:0] BOOT_END_MID = 24'h0015FE;
    localparam logic [23:0] BOOT_END_LARGE = 24'h002BFE;

    typedef enum logic [2:0] {
        CFD_OSC_FAST_RC = 3'h0,
        CFD_OSC_FAST_RC_DIV_PLL = 3'h1,
        CFD_OSC_PRIMARY = 3'h2,
        CFD_OSC_PRIMARY_PLL = 3'h3,
        CFD_OSC_SECONDARY = 3'h4,
        CFD_OSC_LOW_POWER_RC = 3'h5,
        CFD_OSC_LOW_POWER_FAST_RC_DIV = 3'h6,
        CFD_OSC_FAST_RC_DIVIDED = 3'h7
    } cfd_osc_e;

    typedef enum logic [1:0] {
        CFD_ST_INIT = 2'h0,
        CFD_ST_LOAD = 2'h1,
        CFD_ST_READY = 2'h3
    } cfd_state_e;

endpackage : cfd_pkg

/* File: testbench/cfd_chk.sv */
// Port assertions for the configuration fuse decoder.
`timescale 1ns/10ps
module cfd_chk #(
    parameter int ADDR_WIDTH = 24
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tbl_rd,
    input wire logic [ADDR_WIDTH-1:0] tbl_addr,
    input wire logic [7:0] tbl_rdata,
    input wire logic tbl_rvalid,
    input wire logic self_wr_req,
    input wire logic [ADDR_WIDTH-1:0] self_wr_addr,
    input wire logic self_wr_accept,
    input wire logic self_wr_reject,
    input wire logic cfg_loaded,
    input wire logic boot_segment_present,
    input wire logic boot_write_protect,
    input wire logic [ADDR_WIDTH-1:0] boot_segment_end,
    input wire logic general_write_protect
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic mapped;
    logic in_boot;
    assign mapped = tbl_addr inside {24'hF80000, 24'hF80004, 24'hF80006, 24'hF80008,
        24'hF8000A, 24'hF8000C, 24'hF8000E, 24'hF80010};
    assign in_boot = boot_segment_present && self_wr_addr >= 24'h000200 && self_wr_addr <= boot_segment_end;
    rd_answer_a: assert property (tbl_rd |=> tbl_rvalid)
        else $error("read not answered");
    rd_cause_a: assert property (tbl_rvalid |-> $past(tbl_rd))
        else $error("answer without read");
    boot_unimpl_a: assert property (tbl_rd && tbl_addr == 24'hF80000 |=> tbl_rdata[7:4] == 4'h0)
        else $error("boot upper bits not zero");
    unmapped_zero_a: assert property (tbl_rd && !mapped |=> tbl_rdata == 8'h00)
        else $error("unmapped read not zero");
    sw_answer_a: assert property (self_wr_req |=> self_wr_accept != self_wr_reject)
        else $error("self write answer wrong");
    early_reject_a: assert property (self_wr_req && !cfg_loaded |=> self_wr_reject)
        else $error("self write before load taken");
    boot_guard_a: assert property (self_wr_req && cfg_loaded && in_boot && boot_write_protect |=> self_wr_reject)
        else $error("protected boot write taken");
    gen_guard_a: assert property (self_wr_req && cfg_loaded && !in_boot && general_write_protect
        && self_wr_addr < 24'h800000 |=> self_wr_reject)
        else $error("protected general write taken");
    load_time_a: assert property ($rose(rst_n) |-> !cfg_loaded ##1 !cfg_loaded ##1 cfg_loaded)
        else $error("load timing wrong");
    end_code_a: assert property (boot_segment_present ? boot_segment_end inside
        {24'h000AFE, 24'h0015FE, 24'h002BFE} : boot_segment_end == 24'h000000)
        else $error("boot end wrong");
endmodule : cfd_chk
bind cfd_config_fuse_decode cfd_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .tbl_rd(tbl_rd), .tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata),
    .tbl_rvalid(tbl_rvalid), .self_wr_req(self_wr_req), .self_wr_addr(self_wr_addr),
    .self_wr_accept(self_wr_accept), .self_wr_reject(self_wr_reject), .cfg_loaded(cfg_loaded),
    .boot_segment_present(boot_segment_present), .boot_write_protect(boot_write_protect),
    .boot_segment_end(boot_segment_end), .general_write_protect(general_write_protect)
);

/* File: testbench/test_cfd_config_fuse_decode.sv */
// Self-checking bench for the configuration fuse decoder.
`timescale 1ns/10ps
module test_cfd_config_fuse_decode;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic tbl_rd = 1'h0;
    logic tbl_wr = 1'h0;
    logic self_wr_req = 1'h0;
    logic [23:0] tbl_addr = 24'h000000;
    logic [23:0] self_wr_addr = 24'h000000;
    logic [7:0] tbl_wdata = 8'h00;
    logic [7:0] rdata [8];
    logic rvalid [8], acc [8], rej [8], ld [8], pres [8], hsec [8], bwp [8], gcp [8], gwp [8];
    logic tss [8], low_power_rc_oscillator [8], secondary_oscillator [8];
    logic [23:0] bend [8];
    cfd_pkg::cfd_osc_e iosc [8];
    int err_count = 0;
    int compares = 0;
    // Each copy holds code k in the boot and oscillator-select bytes, and the upper two bits of k in the general byte.
    // The copies stand for a full-size part, where every boot size may be programmed.
    for (genvar g = 0; g < 8; g++) begin : g_cfg
        localparam logic [2:0] C = 3'(g);
        cfd_config_fuse_decode #(
            .CFG_INIT({40'hFF_FFFF_FFFF, C, 2'h0, C, 6'h00, C[2:1], 4'h0, C, C[0]})
        ) i_dut (
            .core_clk(core_clk), .rst_n(rst_n), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
            .tbl_wdata(tbl_wdata), .tbl_rdata(rdata[g]), .tbl_rvalid(rvalid[g]), .self_wr_req(self_wr_req),
            .self_wr_addr(self_wr_addr), .self_wr_accept(acc[g]), .self_wr_reject(rej[g]), .cfg_loaded(ld[g]),
            .boot_segment_present(pres[g]), .boot_high_security(hsec[g]), .boot_segment_end(bend[g]),
            .boot_write_protect(bwp[g]), .general_code_protect(gcp[g]), .general_write_protect(gwp[g]),
            .two_speed_startup_enable(tss[g]), .low_power_rc_power_select(low_power_rc_oscillator[g]),
            .secondary_osc_pin_source(secondary_oscillator[g]), .initial_oscillator_select(iosc[g])
        );
    end
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step
    function automatic logic [23:0] seg_end(input logic [2:0] c);
        case (c[1:0])
            2'h2: return 24'h000AFE;
            2'h1: return 24'h0015FE;
            2'h0: return 24'h002BFE;
            default: return 24'h000000;
        endcase
    endfunction : seg_end
    task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp);
        step();
        tbl_rd = 1'h1;
        tbl_addr = a;
        step();
        tbl_rd = 1'h0;
        chk("rvalid", 24'h000001, 24'(rvalid[6]));
        chk("rdata", 24'(exp), 24'(rdata[6]));
    endtask : rd_chk
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        step();
        tbl_wr = 1'h1;
        tbl_addr = a;
        tbl_wdata = d;
        step();
        tbl_wr = 1'h0;
    endtask : wr
    task automatic sw(input logic [23:0] a, input logic pre);
        logic [2:0] c;
        logic inb;
        logic r;
        step();
        self_wr_req = 1'h1;
        self_wr_addr = a;
        step();
        self_wr_req = 1'h0;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            inb = c[1:0] != 2'h3 && a >= 24'h000200 && a <= seg_end(c);
            r = pre || (inb ? !c[0] : (a < 24'h800000 && !c[1]));
            chk("reject", 24'(r), 24'(rej[k]));
            chk("accept", 24'(!r), 24'(acc[k]));
        end
    endtask : sw
    task automatic t_early();
        sw(24'h000300, 1'h1);
        $display("t_early done");
    endtask : t_early
    task automatic t_decode();
        logic [2:0] c;
        logic p;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            p = c[1:0] != 2'h3;
            chk("loaded", 24'h000001, 24'(ld[k]));
            chk("present", 24'(p), 24'(pres[k]));
            chk("high_sec", 24'(p && !c[2]), 24'(hsec[k]));
            chk("seg_end", seg_end(c), bend[k]);
            chk("boot_wp", 24'(!c[0]), 24'(bwp[k]));
            chk("gen_cp", 24'(!c[2]), 24'(gcp[k]));
            chk("gen_wp", 24'(!c[1]), 24'(gwp[k]));
            chk("two_speed", 24'(c[2]), 24'(tss[k]));
            chk("low_power_rc_oscillator_sel", 24'(c[1]), 24'(low_power_rc_oscillator[k]));
            chk("secondary_oscillator_src", 24'(c[0]), 24'(secondary_oscillator[k]));
            chk("init_osc", 24'(c), 24'(iosc[k]));
        end
        $display("t_decode done");
    endtask : t_decode
    task automatic t_table();
        rd_chk(24'hF80000, 8'h0C);
        rd_chk(24'hF80004, 8'h03);
        rd_chk(24'hF80006, 8'hC6);
        rd_chk(24'hF80010, 8'hFF);
        rd_chk(24'hF80002, 8'h00);
        wr(24'hF80000, 8'hF3);
        rd_chk(24'hF80000, 8'h03);
        wr(24'hF80006, 8'hFF);
        rd_chk(24'hF80006, 8'hE7);
        wr(24'hF80004, 8'hFD);
        rd_chk(24'hF80004, 8'h01);
        wr(24'hF80004, 8'hFF);
        rd_chk(24'hF80004, 8'h01);
        $display("t_table done");
    endtask : t_table
    task automatic t_selfwr();
        logic [23:0] al [10] = '{24'h000100, 24'h000200, 24'h000AFE, 24'h000B00, 24'h0015FE,
            24'h001600, 24'h002BFE, 24'h002C00, 24'h7FFFFE, 24'hF80000};
        foreach (al[i]) sw(al[i], 1'h0);
        $display("t_selfwr done");
    endtask : t_selfwr
    task automatic t_reset();
        step();
        rst_n = 1'h0;
        step();
        chk("rst_loaded", 24'h000000, 24'(ld[0]));
        chk("rst_present", 24'h000000, 24'(pres[0]));
        chk("rst_two_speed", 24'h000001, 24'(tss[0]));
        chk("rst_secondary_oscillator_src", 24'h000001, 24'(secondary_oscillator[0]));
        chk("rst_init_osc", 24'h000007, 24'(iosc[0]));
        rst_n = 1'h1;
        step();
        chk("loaded_edge1", 24'h000000, 24'(ld[0]));
        step();
        chk("loaded_edge2", 24'h000001, 24'(ld[0]));
        t_decode();
        rd_chk(24'hF80000, 8'h0C);
        $display("t_reset done");
    endtask : t_reset
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        t_early();
        t_decode();
        t_table();
        t_selfwr();
        t_decode();
        t_reset();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        $display("[ERR] watchdog expected done seen timeout");
        wrap_up();
    end
endmodule : test_cfd_config_fuse_decode
